// ===== shared/mdps_pkg.sv
// ============================================================
// sizes and register map
package mdps_pkg;
   localparam int          LANES_MAX       = 8;
   localparam int          ADDR_W          = 12;
   localparam int          CNT_W           = 16;
   localparam int          LANE_CODE_W     = 3;
   localparam int          MOD_CODE_W      = 2;
   localparam int          FLAG_W          = LANES_MAX + 1;

   localparam logic [11:0] OFS_CTRL        = 12'h000;
   localparam logic [11:0] OFS_TXCTRL      = 12'h004;
   localparam logic [11:0] OFS_STATE       = 12'h008;
   localparam logic [11:0] OFS_FLAG        = 12'h00c;
   localparam logic [11:0] OFS_MASK        = 12'h010;

   // ============================================================
   // field positions
   localparam int          CTRL_DEINIT_LSB = 0;
   localparam int          CTRL_LOW_POWER_BIT_BIT = 16;
   localparam int          TX_DIS_LSB      = 0;
   localparam int          TX_SQ_LSB       = 8;
   localparam int          STATE_MOD_LSB   = 0;
   localparam int          STATE_PWR_BIT   = 4;
   localparam int          STATE_LANE_LSB  = 8;
   localparam int          FLAG_MOD_BIT    = 8;

   // ============================================================
   // reset values
   localparam logic [LANES_MAX-1:0] DEINIT_RST = 8'h00;
   localparam logic [LANES_MAX-1:0] TXBITS_RST = 8'h00;
   localparam logic [FLAG_W-1:0]    FLAG_RST   = 9'h000;
   localparam logic [FLAG_W-1:0]    MASK_RST   = 9'h1ff;

   // ============================================================
   // state codes seen by software
   localparam logic [2:0]  LANE_CODE_ACTIVE  = 3'h4;
   localparam logic [2:0]  LANE_CODE_TXOFF   = 3'h5;
   localparam logic [2:0]  LANE_CODE_CONFIG  = 3'h3;
   localparam logic [2:0]  LANE_CODE_DEINIT  = 3'h2;
   localparam logic [2:0]  LANE_CODE_INACT   = 3'h1;
   localparam logic [1:0]  MOD_CODE_READY    = 2'h2;
   localparam logic [1:0]  MOD_CODE_PWRDN    = 2'h3;
   localparam logic [1:0]  MOD_CODE_LOW_POWER_BIT   = 2'h1;

   // ============================================================
   // timing
   localparam int          CLK_PERIOD_NS   = 4;
   localparam int          TXOFF_TIME_NS   = 100;
   localparam int          DEINIT_TIME_NS  = 400;
   localparam int          PWRDN_TIME_NS   = 2000;
   localparam int          TXOFF_CYCLES    = (TXOFF_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          DEINIT_CYCLES   = (DEINIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          PWRDN_CYCLES    = (PWRDN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ============================================================
   // state types
   typedef enum logic [2:0] {
      LN_ACTIVE, LN_TX_OFF, LN_CONFIGURED, LN_DEINIT, LN_INACTIVE
   } mdps_lane_st_t;

   typedef enum logic [1:0] {
      MD_READY, MD_PWRDN, MD_LOW_POWER_BIT
   } mdps_mod_st_t;

   function automatic logic [2:0] mdps_lane_code(input mdps_lane_st_t st);
      case (st)
         LN_ACTIVE:     mdps_lane_code = LANE_CODE_ACTIVE;
         LN_TX_OFF:     mdps_lane_code = LANE_CODE_TXOFF;
         LN_CONFIGURED: mdps_lane_code = LANE_CODE_CONFIG;
         LN_DEINIT:     mdps_lane_code = LANE_CODE_DEINIT;
         LN_INACTIVE:   mdps_lane_code = LANE_CODE_INACT;
         default:       mdps_lane_code = 3'h0;
      endcase
   endfunction : mdps_lane_code
endpackage : mdps_pkg

// ===== rtl/mdps_lane_seq.sv
// ============================================================
// one data path teardown sequencer
module mdps_lane_seq
   import mdps_pkg::*;
#(
   parameter int TXOFF_CNT  = TXOFF_CYCLES,
   parameter int DEINIT_CNT = DEINIT_CYCLES
) (
   // clock and reset
   input  wire logic                   clk,
   input  wire logic                   resetn,
   // control
   input  wire logic                   deactivate,
   input  wire logic                   txQuiet,
   // status
   output logic [LANE_CODE_W-1:0]      stateCode,
   output logic                        inactive,
   output logic                        enteredInactive
);

   typedef struct packed {
      mdps_lane_st_t          st;
      logic [CNT_W-1:0]       cnt;
      logic [LANE_CODE_W-1:0] code;
      logic                   inact;
      logic                   entered;
   } mdps_lane_reg_t;

   mdps_lane_reg_t s_r;
   mdps_lane_reg_t s_nxt;

   if (TXOFF_CNT < 1 || TXOFF_CNT >= (1 << CNT_W) ||
       DEINIT_CNT < 1 || DEINIT_CNT >= (1 << CNT_W)) begin : g_chk
      $error("lane counts out of range");
   end

   // ============================================================
   // next state
   always_comb begin
      s_nxt         = s_r;
      s_nxt.entered = 1'b0;
      case (s_r.st)
         LN_ACTIVE: begin
            if (deactivate) begin
               s_nxt.st  = LN_TX_OFF;
               s_nxt.cnt = CNT_W'(TXOFF_CNT - 1);
            end
         end
         LN_TX_OFF: begin
            if (txQuiet || s_r.cnt == '0) begin
               s_nxt.st = LN_CONFIGURED;
            end else begin
               s_nxt.cnt = s_r.cnt - CNT_W'(1);
            end
         end
         LN_CONFIGURED: begin
            if (deactivate) begin
               s_nxt.st  = LN_DEINIT;
               s_nxt.cnt = CNT_W'(DEINIT_CNT - 1);
            end
         end
         LN_DEINIT: begin
            if (s_r.cnt == '0) begin
               s_nxt.st      = LN_INACTIVE;
               s_nxt.entered = 1'b1;
            end else begin
               s_nxt.cnt = s_r.cnt - CNT_W'(1);
            end
         end
         LN_INACTIVE: begin
            s_nxt.st = LN_INACTIVE;
         end
         default: begin
            s_nxt.st = LN_ACTIVE;
         end
      endcase
      s_nxt.code  = mdps_lane_code(s_nxt.st);
      s_nxt.inact = (s_nxt.st == LN_INACTIVE);
   end

   // ============================================================
   // state register
   always_ff @(posedge clk) begin
      if (!resetn) begin
         s_r.st      <= LN_ACTIVE;
         s_r.cnt     <= '0;
         s_r.code    <= LANE_CODE_ACTIVE;
         s_r.inact   <= 1'b0;
         s_r.entered <= 1'b0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign stateCode       = s_r.code;
   assign inactive        = s_r.inact;
   assign enteredInactive = s_r.entered;

endmodule : mdps_lane_seq

// ===== rtl/mdps_powerdown_seq.sv
// Functional notes
// - lp request rise in ready starts teardown
// - tx bits zero: tx off goes configured
// - redeinit true: configured goes deinitializing
// - deinitializing releases resources, then inactive
// - entering inactive sets lane changed flag
// - host reads flags; read clears, pin released
// - paths inactive plus entry: powering down
// - powering down reduces power, then low power
// - entering low power sets module flag
// - software deinit bits with pin high: teardown
// - software low power bit gives entry signal
module mdps_powerdown_seq
   import mdps_pkg::*;
#(
   parameter int NLANES     = LANES_MAX,
   parameter int TXOFF_CNT  = TXOFF_CYCLES,
   parameter int DEINIT_CNT = DEINIT_CYCLES,
   parameter int PWRDN_CNT  = PWRDN_CYCLES
) (
   // clock and reset
   input  wire logic                clk,
   input  wire logic                resetn,
   // apb slave
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [ADDR_W-1:0]   paddr,
   input  wire logic [31:0]         pwdata,
   input  wire logic [3:0]          pstrb,
   output logic [31:0]              prdata,
   output logic                     pready,
   output logic                     pslverr,
   // module pins
   input  wire logic                lowPowerReq,
   output logic                     interruptN,
   // power control
   output logic                     powerReduce
);

   // ============================================================
   // state
   typedef struct packed {
      logic [LANES_MAX-1:0] deinit;
      logic                 lowPwrBit;
      logic [LANES_MAX-1:0] txDis;
      logic [LANES_MAX-1:0] txSq;
      logic [FLAG_W-1:0]    flag;
      logic [FLAG_W-1:0]    mask;
      mdps_mod_st_t         modSt;
      logic [CNT_W-1:0]     cnt;
      logic                 hwDeact;
      logic                 lpPrev;
      logic                 pwrRed;
      logic [31:0]          rdata;
      logic                 rdy;
      logic                 err;
      logic                 intN;
   } mdps_top_reg_t;

   mdps_top_reg_t s_r;
   mdps_top_reg_t s_nxt;

   logic [LANES_MAX-1:0]   laneDeact;
   logic [LANES_MAX-1:0]   laneQuiet;
   logic [LANES_MAX-1:0]   laneInact;
   logic [LANES_MAX-1:0]   laneEntered;
   logic [LANE_CODE_W*LANES_MAX-1:0] laneCodes;

   if (NLANES < 1 || NLANES > LANES_MAX ||
       PWRDN_CNT < 1 || PWRDN_CNT >= (1 << CNT_W)) begin : g_chk
      $error("lane count or power down count out of range");
   end

   // ============================================================
   // helpers
   function automatic logic [31:0] mdps_merge(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0]  strb);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[8*b +: 8] = wd[8*b +: 8];
         end
      end
      mdps_merge = res;
   endfunction : mdps_merge

   function automatic logic [1:0] mdps_mod_code(input mdps_mod_st_t st);
      case (st)
         MD_READY:  mdps_mod_code = MOD_CODE_READY;
         MD_PWRDN:  mdps_mod_code = MOD_CODE_PWRDN;
         MD_LOW_POWER_BIT: mdps_mod_code = MOD_CODE_LOW_POWER_BIT;
         default:   mdps_mod_code = 2'h0;
      endcase
   endfunction : mdps_mod_code

   function automatic logic mdps_is(input logic [ADDR_W-1:0] a,
                                    input logic [11:0]       ofs);
      mdps_is = (a == ofs);
   endfunction : mdps_is

   // ============================================================
   // data path sequencers
   for (genvar i = 0; i < LANES_MAX; i++) begin : g_lane
      if (i < NLANES) begin : g_on
         assign laneDeact[i] = s_r.hwDeact | (lowPowerReq & s_r.deinit[i]);
         assign laneQuiet[i] = ~s_r.txDis[i] & ~s_r.txSq[i];
         mdps_lane_seq #(
            .TXOFF_CNT  (TXOFF_CNT),
            .DEINIT_CNT (DEINIT_CNT)
         ) u_lane (
            .clk             (clk),
            .resetn          (resetn),
            .deactivate      (laneDeact[i]),
            .txQuiet         (laneQuiet[i]),
            .stateCode       (laneCodes[LANE_CODE_W*i +: LANE_CODE_W]),
            .inactive        (laneInact[i]),
            .enteredInactive (laneEntered[i])
         );
      end else begin : g_off
         assign laneDeact[i]                              = 1'b0;
         assign laneQuiet[i]                              = 1'b1;
         assign laneInact[i]                              = 1'b1;
         assign laneEntered[i]                            = 1'b0;
         assign laneCodes[LANE_CODE_W*i +: LANE_CODE_W]   = '0;
      end
   end

   // ============================================================
   // next state
   always_comb begin
      logic                 lpRise;
      logic                 lowPwrEntry;
      logic                 setup;
      logic                 done;
      logic                 mapped;
      logic [31:0]          rd;
      logic [31:0]          wv;
      logic [FLAG_W-1:0]    setF;
      logic [FLAG_W-1:0]    clrF;
      logic [LANES_MAX-1:0] laneMask;

      lpRise      = 1'b0;
      lowPwrEntry = 1'b0;
      setup       = 1'b0;
      done        = 1'b0;
      mapped      = 1'b0;
      rd          = 32'h0000_0000;
      wv          = 32'h0000_0000;
      setF        = '0;
      clrF        = '0;
      laneMask    = LANES_MAX'((9'h001 << NLANES) - 9'h001);
      s_nxt       = s_r;

      // low power pin edge
      lpRise       = lowPowerReq & ~s_r.lpPrev;
      s_nxt.lpPrev = lowPowerReq;
      if (lpRise && s_r.modSt == MD_READY) begin
         s_nxt.hwDeact = 1'b1;
      end

      // module state machine
      lowPwrEntry = s_r.hwDeact | s_r.lowPwrBit;
      case (s_r.modSt)
         MD_READY: begin
            if (lowPwrEntry && (&laneInact)) begin
               s_nxt.modSt  = MD_PWRDN;
               s_nxt.cnt    = CNT_W'(PWRDN_CNT - 1);
               s_nxt.pwrRed = 1'b1;
            end
         end
         MD_PWRDN: begin
            if (s_r.cnt == '0) begin
               s_nxt.modSt = MD_LOW_POWER_BIT;
               setF[FLAG_MOD_BIT] = 1'b1;
            end else begin
               s_nxt.cnt = s_r.cnt - CNT_W'(1);
            end
         end
         MD_LOW_POWER_BIT: begin
            s_nxt.modSt = MD_LOW_POWER_BIT;
         end
         default: begin
            s_nxt.modSt = MD_READY;
         end
      endcase
      setF[LANES_MAX-1:0] = laneEntered;

      // apb decode in setup, answer in access
      setup = psel & ~penable;
      done  = psel & penable & s_r.rdy;
      if (mdps_is(paddr, OFS_CTRL)) begin
         mapped = 1'b1;
         rd[CTRL_DEINIT_LSB +: LANES_MAX] = s_r.deinit;
         rd[CTRL_LOW_POWER_BIT_BIT]              = s_r.lowPwrBit;
      end else if (mdps_is(paddr, OFS_TXCTRL)) begin
         mapped = 1'b1;
         rd[TX_DIS_LSB +: LANES_MAX] = s_r.txDis;
         rd[TX_SQ_LSB +: LANES_MAX]  = s_r.txSq;
      end else if (mdps_is(paddr, OFS_STATE)) begin
         mapped = 1'b1;
         rd[STATE_MOD_LSB +: MOD_CODE_W]                = mdps_mod_code(s_r.modSt);
         rd[STATE_PWR_BIT]                              = s_r.pwrRed;
         rd[STATE_LANE_LSB +: LANE_CODE_W*LANES_MAX]    = laneCodes;
      end else if (mdps_is(paddr, OFS_FLAG)) begin
         mapped = 1'b1;
         rd[FLAG_W-1:0] = s_r.flag;
      end else if (mdps_is(paddr, OFS_MASK)) begin
         mapped = 1'b1;
         rd[FLAG_W-1:0] = s_r.mask;
      end
      s_nxt.rdy = setup;
      if (setup) begin
         s_nxt.rdata = pwrite ? 32'h0000_0000 : rd;
         s_nxt.err   = ~mapped;
      end else if (done) begin
         s_nxt.rdata = 32'h0000_0000;
         s_nxt.err   = 1'b0;
      end

      // register writes and flag clears at completion
      if (done && pwrite) begin
         wv = mdps_merge(rd, pwdata, pstrb);
         if (mdps_is(paddr, OFS_CTRL)) begin
            s_nxt.deinit    = wv[CTRL_DEINIT_LSB +: LANES_MAX] & laneMask;
            s_nxt.lowPwrBit = wv[CTRL_LOW_POWER_BIT_BIT];
         end else if (mdps_is(paddr, OFS_TXCTRL)) begin
            s_nxt.txDis = wv[TX_DIS_LSB +: LANES_MAX] & laneMask;
            s_nxt.txSq  = wv[TX_SQ_LSB +: LANES_MAX] & laneMask;
         end else if (mdps_is(paddr, OFS_FLAG)) begin
            clrF = pwdata[FLAG_W-1:0] & {pstrb[1], {LANES_MAX{pstrb[0]}}};
         end else if (mdps_is(paddr, OFS_MASK)) begin
            s_nxt.mask = wv[FLAG_W-1:0];
         end
      end else if (done && mdps_is(paddr, OFS_FLAG)) begin
         clrF = s_r.rdata[FLAG_W-1:0];
      end

      // sticky flags, set wins over clear
      s_nxt.flag = (s_r.flag & ~clrF) | setF;
      s_nxt.intN = ~|(s_nxt.flag & s_nxt.mask);
   end

   // ============================================================
   // state register
   always_ff @(posedge clk) begin
      if (!resetn) begin
         s_r.deinit    <= DEINIT_RST;
         s_r.lowPwrBit <= 1'b0;
         s_r.txDis     <= TXBITS_RST;
         s_r.txSq      <= TXBITS_RST;
         s_r.flag      <= FLAG_RST;
         s_r.mask      <= MASK_RST;
         s_r.modSt     <= MD_READY;
         s_r.cnt       <= '0;
         s_r.hwDeact   <= 1'b0;
         s_r.lpPrev    <= 1'b1;
         s_r.pwrRed    <= 1'b0;
         s_r.rdata     <= 32'h0000_0000;
         s_r.rdy       <= 1'b0;
         s_r.err       <= 1'b0;
         s_r.intN      <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ============================================================
   // outputs
   assign prdata      = s_r.rdata;
   assign pready      = s_r.rdy;
   assign pslverr     = s_r.err;
   assign interruptN  = s_r.intN;
   assign powerReduce = s_r.pwrRed;

endmodule : mdps_powerdown_seq

// ===== sim/mdps_powerdown_seq_chk.sv
// ============================================================
// port checker for the power-down sequencer
module mdps_powerdown_seq_chk
   import mdps_pkg::*;
#(
   parameter int TXOFF_CNT  = TXOFF_CYCLES,
   parameter int DEINIT_CNT = DEINIT_CYCLES,
   parameter int PWRDN_CNT  = PWRDN_CYCLES
) (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              resetn,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   input  wire logic [3:0]        pstrb,
   input  wire logic [31:0]       prdata,
   input  wire logic              pready,
   input  wire logic              pslverr,
   // pins
   input  wire logic              lowPowerReq,
   input  wire logic              interruptN,
   input  wire logic              powerReduce
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int IRQ_LIM = TXOFF_CNT + DEINIT_CNT + PWRDN_CNT + 16;
   localparam int PD_LIM  = PWRDN_CNT + 4;
   logic [FLAG_W-1:0] maskShadow_r;
   logic              xferDone;
   assign xferDone = psel && penable && pready;
   // ============================================================
   // mask copy kept from bus writes
   always_ff @(posedge clk) begin
      if (!resetn) begin
         maskShadow_r <= MASK_RST;
      end else if (xferDone && pwrite && paddr == OFS_MASK) begin
         if (pstrb[0]) maskShadow_r[7:0] <= pwdata[7:0];
         if (pstrb[1]) maskShadow_r[8] <= pwdata[8];
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);
   sequence sSetup;
      psel && !penable;
   endsequence
   sequence sFlagRead;
      sSetup ##0 !pwrite && paddr == OFS_FLAG;
   endsequence
   // ============================================================
   // assertions
   chk_ready_after_setup: assert property (sSetup |=> pready)
      else $error("no ready after setup");
   chk_ready_one_cycle: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   chk_err_with_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside access");
   chk_unmapped_error: assert property (sSetup ##0 paddr > OFS_MASK |=> pslverr)
      else $error("unmapped access without error");
   chk_power_holds: assert property (powerReduce |=> powerReduce)
      else $error("power reduce dropped");
   chk_irq_release: assert property ($rose(interruptN) |->
      $past(xferDone) && ($past(paddr) == OFS_FLAG || $past(paddr) == OFS_MASK))
      else $error("interrupt released without clear");
   chk_low_means_flag: assert property (sFlagRead ##0 !interruptN && !$past(pready)
      && maskShadow_r == 9'h1ff |=> prdata[8:0] != 9'h000)
      else $error("interrupt low with no flag");
   chk_rise_gives_irq: assert property ($rose(lowPowerReq) && !powerReduce
      && maskShadow_r == 9'h1ff |-> ##[1:IRQ_LIM] !interruptN)
      else $error("no interrupt after request rise");
   chk_low_power_bit_irq: assert property ($rose(powerReduce) && maskShadow_r[8]
      |-> ##[1:PD_LIM] !interruptN)
      else $error("no interrupt after power down");
endmodule : mdps_powerdown_seq_chk

// ===== sim/mdps_host_model.sv
// ============================================================
// host controller: apb master and low power pin
module mdps_host_model
   import mdps_pkg::*;
(
   // clock
   input  wire logic              clk,
   // apb master
   output logic                   psel        = 1'b0,
   output logic                   penable     = 1'b0,
   output logic                   pwrite      = 1'b0,
   output logic [ADDR_W-1:0]      paddr       = 12'h000,
   output logic [31:0]            pwdata      = 32'h0,
   output logic [3:0]             pstrb       = 4'hf,
   input  wire logic [31:0]       prdata,
   input  wire logic              pready,
   input  wire logic              pslverr,
   // module pins
   output logic                   lowPowerReq = 1'b0,
   input  wire logic              interruptN
);
   timeunit 1ns;
   timeprecision 1ps;
   // ============================================================
   // one transfer, held until pready
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      paddr   <= ~a;
      pwdata  <= ~d;
      @(posedge clk);
   endtask : xfer
   task automatic setPin(input logic v);
      lowPowerReq <= v;
      @(posedge clk);
   endtask : setPin
   task automatic swDeinit(input logic [7:0] lanes);
      logic [31:0] rd;
      logic        e;
      lowPowerReq <= 1'b1;
      xfer(1'b1, OFS_CTRL, {24'h0, lanes}, rd, e);
   endtask : swDeinit
   task automatic swLowPower();
      logic [31:0] rd;
      logic        e;
      xfer(1'b1, OFS_CTRL, 32'h0001_00ff, rd, e);
   endtask : swLowPower
   task automatic readFlags(output logic [31:0] f);
      logic e;
      xfer(1'b0, OFS_FLAG, 32'h0, f, e);
   endtask : readFlags
endmodule : mdps_host_model

// ===== sim/test_mdps_powerdown_seq.sv
module test_mdps_powerdown_seq
   import mdps_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TXOFF_T = 3;
   localparam int DEINIT_T = 4;
   localparam int PWRDN_T = 20;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, lowPowerReq, interruptN, powerReduce;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] pstrb;
   int miscompares = 0;
   int samplesChecked = 0;
   always #2 clk = ~clk;
   mdps_powerdown_seq #(.NLANES(8), .TXOFF_CNT(TXOFF_T), .DEINIT_CNT(DEINIT_T),
      .PWRDN_CNT(PWRDN_T)) dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .lowPowerReq(lowPowerReq),
      .interruptN(interruptN), .powerReduce(powerReduce));
   mdps_host_model host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .lowPowerReq(lowPowerReq), .interruptN(interruptN));
   // ============================================================
   // helpers
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      samplesChecked++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   function automatic logic [31:0] stExp(logic [1:0] m, logic p, logic [2:0] ln);
      logic [31:0] v;
      v = 32'h0;
      v[1:0] = m;
      v[STATE_PWR_BIT] = p;
      for (int i = 0; i < 8; i++) v[STATE_LANE_LSB+3*i +: 3] = ln;
      return v;
   endfunction : stExp
   task automatic rdChk(input logic [11:0] a, input logic [31:0] exp, input string what);
      logic [31:0] d;
      logic        e;
      host.xfer(1'b0, a, 32'h0, d, e);
      check(what, exp, d);
   endtask : rdChk
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      host.xfer(1'b1, a, d, r, e);
   endtask : wr
   task automatic doReset();
      resetn <= 1'b0;
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
   endtask : doReset
   task automatic waitIrq();
      int n;
      n = 0;
      while (interruptN !== 1'b0 && n < 2000) begin
         @(posedge clk);
         n++;
      end
      check("irq wait", 32'h0, {31'h0, interruptN});
   endtask : waitIrq
   // ============================================================
   // scenarios
   task automatic testRegs();
      logic [31:0] d;
      logic        e;
      rdChk(OFS_CTRL, 32'h0, "ctrl");
      rdChk(OFS_TXCTRL, 32'h0, "txctrl");
      rdChk(OFS_FLAG, 32'h0, "flag");
      rdChk(OFS_MASK, 32'h1ff, "mask");
      wr(OFS_STATE, 32'hffff_ffff);
      rdChk(OFS_STATE, stExp(MOD_CODE_READY, 1'b0, LANE_CODE_ACTIVE), "state");
      host.xfer(1'b0, 12'h020, 32'h0, d, e);
      check("unmapped rd", 32'h1, {31'h0, e});
      check("unmapped data", 32'h0, d);
      host.xfer(1'b1, 12'h014, 32'h1, d, e);
      check("unmapped wr", 32'h1, {31'h0, e});
      $display("test regs done");
   endtask : testRegs
   task automatic testHw();
      logic [31:0] f;
      wr(OFS_CTRL, 32'hff);
      repeat (10) @(posedge clk);
      rdChk(OFS_STATE, stExp(MOD_CODE_READY, 1'b0, LANE_CODE_ACTIVE), "pin low");
      wr(OFS_CTRL, 32'h0);
      host.setPin(1'b1);
      waitIrq();
      host.readFlags(f);
      check("lane flags", 32'h0ff, f);
      repeat (2) @(posedge clk);
      check("irq cleared", 32'h1, {31'h0, interruptN});
      check("power reduce", 32'h1, {31'h0, powerReduce});
      waitIrq();
      host.readFlags(f);
      check("module flag", 32'h100, f);
      rdChk(OFS_STATE, stExp(MOD_CODE_LOW_POWER_BIT, 1'b1, LANE_CODE_INACT), "low_power_bit");
      check("irq end", 32'h1, {31'h0, interruptN});
      $display("test hardware done");
   endtask : testHw
   task automatic testSw();
      logic [31:0] d;
      logic        e;
      wr(OFS_MASK, 32'h100);
      wr(OFS_TXCTRL, 32'h1);
      host.swDeinit(8'hff);
      for (int n = 0; n < 40; n++) begin
         host.xfer(1'b0, OFS_STATE, 32'h0, d, e);
         if (d[31:8] === stExp(2'h0, 1'b0, LANE_CODE_INACT) >> 8) break;
      end
      check("sw state", stExp(MOD_CODE_READY, 1'b0, LANE_CODE_INACT), d);
      check("masked irq", 32'h1, {31'h0, interruptN});
      rdChk(OFS_FLAG, 32'h0ff, "sw flags");
      wr(OFS_MASK, 32'h1ff);
      host.swLowPower();
      waitIrq();
      check("sw power", 32'h1, {31'h0, powerReduce});
      wr(OFS_FLAG, 32'h100);
      repeat (2) @(posedge clk);
      check("w1c irq", 32'h1, {31'h0, interruptN});
      rdChk(OFS_FLAG, 32'h0, "w1c flag");
      $display("test software done");
   endtask : testSw
   task automatic reportAndStop();
      $display("checks %0d mismatches %0d", samplesChecked, miscompares);
      if (miscompares == 0 && samplesChecked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : reportAndStop
   initial begin
      doReset();
      testRegs();
      testHw();
      resetn <= 1'b0;
      host.setPin(1'b1);
      doReset();
      testSw();
      reportAndStop();
   end
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      $display("watchdog expired");
      reportAndStop();
   end
endmodule : test_mdps_powerdown_seq
bind mdps_powerdown_seq mdps_powerdown_seq_chk #(.TXOFF_CNT(TXOFF_CNT),
   .DEINIT_CNT(DEINIT_CNT), .PWRDN_CNT(PWRDN_CNT)) chk (.clk(clk), .resetn(resetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .lowPowerReq(lowPowerReq), .interruptN(interruptN), .powerReduce(powerReduce));
